// File: verilog/rmc_pkg.sv
/*
 rmc_pkg: constants shared by the mode command reset handler.
 Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package rmc_pkg;
  // mode codes handled here
  localparam logic [4:0] MC_OVR_TF = 5'h07;
  localparam logic [4:0] MC_RST_RT = 5'h08;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_IEN = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_PEND = 8'h0C;
  // config register fields
  localparam int CFG_UMC = 0;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RST = 8'h00;
  // interrupt enable fields
  localparam int IEN_CMD = 0;
  localparam int IEN_BC = 1;
  localparam int IEN_ILL = 2;
  localparam int IEN_ME = 3;
  localparam logic [3:0] IEN_RST = 4'h0;
  // status register fields
  localparam int ST_ME = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_BCR = 2;
  localparam int ST_TFI = 3;
  localparam int ST_SDA = 4;
  localparam int ST_SDB = 5;
  localparam logic [5:0] ST_RST = 6'h00;
  // message info word fields
  localparam int MI_BUS = 0;
  localparam int MI_ME = 1;
  localparam int MI_ILL = 2;
  localparam int MI_RT_TO_RT_FLAG = 3;
  localparam int MI_WCT = 4;
  localparam int MI_GAP = 5;
  localparam logic [15:0] MI_CLEAN = 16'h0000;
  localparam logic [15:0] BITW_CLR = 16'h0000;
endpackage

// File: verilog/rmc_handler.sv
/*
 rmc_handler: response logic for the override-flag-inhibit and
 terminal-reset mode commands of a 1553 remote terminal.
 Assumes a decoder on the same clock that gives one msg_stb_i pulse
 per finished mode command with its fields, and an encoder that
 pulses status_sent_i when a status word has gone out.
*/
// The register offsets and the Wishbone interface to the registers were decided locally.
// What this block does
// - mode 01000 with T/R one is reset
// - reset clears ME, sends status unless broadcast, updates descriptor
// - reset info word: bus id, no errors
// - after status, clear ME, busy, BCR
// - reset clears built-in-test word to zero
// - reset cancels transmitter shutdown on both buses
// - reset removes terminal flag inhibit
// - reset leaves host configuration registers unchanged
// - invalid or undefined-invalid commands fully ignored
// - ignored commands never consult illegalization bit
// - in-form T/R zero clears ME, status unless broadcast
// - in-form descriptor: accessed, broadcast, toggle ping-pong
// - in-form info word clean; command, broadcast interrupts
// - illegalized T/R zero sets ME, status unless broadcast
// - illegalized info word flags; three interrupts offered
// - trailing data word: no status, ME set
// - override with data word: ME, word count error
// - reset with data word: ME, gap error
// - valid override clears terminal flag inhibit
`timescale 1ns/10ps
module rmc_handler
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic msg_stb_i,
  input wire logic msg_word_ok_i,
  input wire logic msg_tr_i,
  input wire logic [4:0] msg_mode_i,
  input wire logic msg_broadcast_flag_i,
  input wire logic msg_bus_i,
  input wire logic msg_illeg_i,
  input wire logic msg_extra_i,
  input wire logic tf_inh_set_i,
  input wire logic status_sent_i,
  output logic stat_tx_o,
  output logic desc_wr_o,
  output logic desc_acc_o,
  output logic desc_broadcast_flag_o,
  output logic desc_pp_o,
  output logic info_wr_o,
  output logic [15:0] info_o,
  output logic bitw_wr_o,
  output logic [15:0] bitw_o,
  output logic msg_err_o,
  output logic busy_o,
  output logic bcr_o,
  output logic tf_inh_o,
  output logic [1:0] tx_shut_o,
  output logic reset_req_o,
  output logic irq_cmd_o,
  output logic irq_bc_o,
  output logic irq_ill_o,
  output logic irq_me_o
);
  typedef enum logic [1:0]
  {
    RMC_IDLE = 2'b01,
    RMC_WAIT = 2'b10
  } rmc_st_t;

  function automatic logic hit(input logic [7:0] ofs);
    hit = wb_adr_i[7:2] == ofs[7:2];
  endfunction

  logic [rmc_pkg::CFG_W-1:0] cfg_q;
  logic [3:0] ien_q;
  logic [5:0] st_q;
  logic [1:0] pp_q;
  logic pend_q;
  rmc_st_t rst_st_q;
  logic wb_req;
  logic wr_en;
  logic is7;
  logic is8;
  logic act;
  logic ign;
  // combinational decision for one message
  logic d_stat;
  logic d_me;
  logic d_bcr;
  logic d_acc;
  logic d_bc;
  logic [15:0] d_info;
  logic d_icmd;
  logic d_ibc;
  logic d_iill;
  logic d_ime;
  logic d_norm;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = wb_req && wb_we_i && wb_sel_i[0] && ce_i;
  assign is7 = msg_mode_i == rmc_pkg::MC_OVR_TF;
  assign is8 = msg_mode_i == rmc_pkg::MC_RST_RT;
  assign act = msg_stb_i && (is7 || is8) && ce_i;
  // option checked before the table bit ever is
  assign ign = !msg_word_ok_i ||
    (!msg_tr_i && cfg_q[rmc_pkg::CFG_UMC]);
  assign d_norm = act && !ign && msg_tr_i && !msg_extra_i;

  always_comb
  begin
    d_stat = 1'b0;
    d_me = 1'b0;
    d_bcr = 1'b0;
    d_acc = 1'b0;
    d_bc = msg_broadcast_flag_i;
    d_info = rmc_pkg::MI_CLEAN;
    d_info[rmc_pkg::MI_BUS] = msg_bus_i;
    d_icmd = 1'b1;
    d_ibc = msg_broadcast_flag_i;
    d_iill = 1'b0;
    d_ime = 1'b0;
    if (msg_extra_i)
    begin
      d_me = 1'b1;
      d_acc = 1'b1;
      d_bc = 1'b0;
      d_ibc = 1'b0;
      d_ime = 1'b1;
      d_info[rmc_pkg::MI_ME] = 1'b1;
      d_info[rmc_pkg::MI_WCT] = is7;
      d_info[rmc_pkg::MI_GAP] = is8;
    end
    else if (msg_tr_i)
    begin
      d_stat = !msg_broadcast_flag_i;
      d_bcr = msg_broadcast_flag_i;
    end
    else if (!msg_illeg_i)
    begin
      d_stat = !msg_broadcast_flag_i;
      d_bcr = msg_broadcast_flag_i;
      d_acc = 1'b1;
    end
    else
    begin
      d_me = 1'b1;
      d_stat = !msg_broadcast_flag_i;
      d_bcr = msg_broadcast_flag_i;
      d_acc = 1'b1;
      d_iill = 1'b1;
      d_info[rmc_pkg::MI_ME] = 1'b1;
      d_info[rmc_pkg::MI_ILL] = 1'b1;
    end
  end

  // bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else if (ce_i)
      wb_ack_o <= wb_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (ce_i && wb_req && !wb_we_i)
    begin
      wb_dat_o <= 32'h0000_0000;
      if (hit(rmc_pkg::OFS_CFG))
        wb_dat_o[rmc_pkg::CFG_W-1:0] <= cfg_q;
      else if (hit(rmc_pkg::OFS_IEN))
        wb_dat_o[3:0] <= ien_q;
      else if (hit(rmc_pkg::OFS_STAT))
        wb_dat_o[5:0] <= st_q;
      else if (hit(rmc_pkg::OFS_PEND))
        wb_dat_o[0] <= pend_q;
    end
  end

  // only software writes configuration; commands never do
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_q <= rmc_pkg::CFG_RST;
    else if (wr_en && hit(rmc_pkg::OFS_CFG))
      cfg_q <= wb_dat_i[rmc_pkg::CFG_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ien_q <= rmc_pkg::IEN_RST;
    else if (wr_en && hit(rmc_pkg::OFS_IEN))
      ien_q <= wb_dat_i[3:0];
  end

  // status: software writes first, message handling overrides
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= rmc_pkg::ST_RST;
    else if (ce_i)
    begin
      if (wr_en && hit(rmc_pkg::OFS_STAT))
      begin
        st_q[rmc_pkg::ST_BUSY] <= wb_dat_i[rmc_pkg::ST_BUSY];
        st_q[rmc_pkg::ST_SDA] <= wb_dat_i[rmc_pkg::ST_SDA];
        st_q[rmc_pkg::ST_SDB] <= wb_dat_i[rmc_pkg::ST_SDB];
      end
      if (tf_inh_set_i)
        st_q[rmc_pkg::ST_TFI] <= 1'b1;
      if (rst_st_q == RMC_WAIT && status_sent_i)
      begin
        st_q[rmc_pkg::ST_ME] <= 1'b0;
        st_q[rmc_pkg::ST_BUSY] <= 1'b0;
        st_q[rmc_pkg::ST_BCR] <= 1'b0;
      end
      if (act && !ign)
      begin
        st_q[rmc_pkg::ST_ME] <= d_me;
        if (d_bcr)
          st_q[rmc_pkg::ST_BCR] <= 1'b1;
        if (d_norm)
          st_q[rmc_pkg::ST_TFI] <= 1'b0;
        if (d_norm && is8)
        begin
          st_q[rmc_pkg::ST_SDA] <= 1'b0;
          st_q[rmc_pkg::ST_SDB] <= 1'b0;
          // broadcast has no status word: clear what we can now
          if (msg_broadcast_flag_i)
            st_q[rmc_pkg::ST_BUSY] <= 1'b0;
        end
      end
    end
  end

  // waits for the status word of a terminal reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rst_st_q <= RMC_IDLE;
    else if (ce_i)
    begin
      unique case (rst_st_q)
        RMC_IDLE:
        begin
          if (d_norm && is8 && !msg_broadcast_flag_i)
            rst_st_q <= RMC_WAIT;
        end
        RMC_WAIT:
        begin
          if (status_sent_i)
            rst_st_q <= RMC_IDLE;
        end
        default:
          rst_st_q <= RMC_IDLE;
      endcase
    end
  end

  // host must finish the reset; set wins over a clearing write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (ce_i)
    begin
      if (d_norm && is8)
        pend_q <= 1'b1;
      else if (wr_en && hit(rmc_pkg::OFS_PEND) && wb_dat_i[0])
        pend_q <= 1'b0;
    end
  end

  // ping-pong state per command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pp_q <= 2'b00;
    else if (act && !ign)
    begin
      if (is7)
        pp_q[0] <= !pp_q[0];
      else
        pp_q[1] <= !pp_q[1];
    end
  end

  // one-cycle pulses and their data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_tx_o <= 1'b0;
      desc_wr_o <= 1'b0;
      info_wr_o <= 1'b0;
      bitw_wr_o <= 1'b0;
      desc_acc_o <= 1'b0;
      desc_broadcast_flag_o <= 1'b0;
      desc_pp_o <= 1'b0;
      info_o <= rmc_pkg::MI_CLEAN;
    end
    else if (ce_i)
    begin
      stat_tx_o <= act && !ign && d_stat;
      desc_wr_o <= act && !ign;
      info_wr_o <= act && !ign;
      bitw_wr_o <= d_norm && is8;
      if (act && !ign)
      begin
        desc_acc_o <= d_acc;
        desc_broadcast_flag_o <= d_bc;
        desc_pp_o <= is7 ? !pp_q[0] : !pp_q[1];
        info_o <= d_info;
      end
    end
  end

  assign bitw_o = rmc_pkg::BITW_CLR;

  // interrupt offers, gated by the host's enables
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_cmd_o <= 1'b0;
      irq_bc_o <= 1'b0;
      irq_ill_o <= 1'b0;
      irq_me_o <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_cmd_o <= act && !ign && d_icmd && ien_q[rmc_pkg::IEN_CMD];
      irq_bc_o <= act && !ign && d_ibc && ien_q[rmc_pkg::IEN_BC];
      irq_ill_o <= act && !ign && d_iill && ien_q[rmc_pkg::IEN_ILL];
      irq_me_o <= act && !ign && d_ime && ien_q[rmc_pkg::IEN_ME];
    end
  end

  assign msg_err_o = st_q[rmc_pkg::ST_ME];
  assign busy_o = st_q[rmc_pkg::ST_BUSY];
  assign bcr_o = st_q[rmc_pkg::ST_BCR];
  assign tf_inh_o = st_q[rmc_pkg::ST_TFI];
  assign tx_shut_o = {st_q[rmc_pkg::ST_SDB], st_q[rmc_pkg::ST_SDA]};
  assign reset_req_o = pend_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_msg(logic c);
    act && c;
  endsequence
  sequence s_quiet;
    !stat_tx_o && !info_wr_o && !desc_wr_o && !irq_cmd_o;
  endsequence

  property p_ignore;
    s_msg(ign) |=> s_quiet;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ignored command produced activity");

  property p_rst_stat;
    s_msg(d_norm && is8 && !msg_broadcast_flag_i)
      |=> stat_tx_o && !msg_err_o && info_wr_o && info_o[5:1] == 5'h00;
  endproperty
  a_rst_stat: assert property (p_rst_stat)
    else $error("terminal reset response wrong");

  property p_rst_clean;
    s_msg(d_norm && is8) |=> tx_shut_o == 2'b00 && !tf_inh_o && bitw_wr_o;
  endproperty
  a_rst_clean: assert property (p_rst_clean)
    else $error("terminal reset left shutdown or inhibit");

  // a message taken on the same edge overrides the clear
  property p_after_tx;
    rst_st_q == RMC_WAIT && status_sent_i && ce_i && !(act && !ign)
      |=> !msg_err_o && !busy_o && !bcr_o;
  endproperty
  a_after_tx: assert property (p_after_tx)
    else $error("status bits not cleared after status");

  property p_ovr_tf;
    s_msg(d_norm && is7 && !tf_inh_set_i) |=> !tf_inh_o;
  endproperty
  a_ovr_tf: assert property (p_ovr_tf)
    else $error("override did not clear flag inhibit");

  property p_extra;
    s_msg(!ign && msg_extra_i) |=> !stat_tx_o && msg_err_o
      && info_o[rmc_pkg::MI_ME] && !desc_broadcast_flag_o && desc_acc_o
      && (info_o[rmc_pkg::MI_GAP] != info_o[rmc_pkg::MI_WCT]);
  endproperty
  a_extra: assert property (p_extra)
    else $error("trailing data word case wrong");

  property p_illeg;
    s_msg(!ign && !msg_tr_i && msg_illeg_i && !msg_extra_i)
      |=> msg_err_o && info_o[rmc_pkg::MI_ILL] && desc_acc_o;
  endproperty
  a_illeg: assert property (p_illeg)
    else $error("illegalized command not flagged");

  property p_inform;
    s_msg(!ign && !msg_tr_i && !msg_illeg_i && !msg_extra_i)
      |=> !msg_err_o && stat_tx_o == !$past(msg_broadcast_flag_i)
      && info_o[rmc_pkg::MI_ILL] == 1'b0;
  endproperty
  a_inform: assert property (p_inform)
    else $error("in-form response wrong");

  property p_irq_gate;
    (!irq_cmd_o || $past(ien_q[rmc_pkg::IEN_CMD]))
      && (!irq_bc_o || $past(ien_q[rmc_pkg::IEN_BC]))
      && (!irq_ill_o || $past(ien_q[rmc_pkg::IEN_ILL]))
      && (!irq_me_o || $past(ien_q[rmc_pkg::IEN_ME]));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised while disabled");

  property p_cfg_kept;
    s_msg(!wr_en) |=> $stable(cfg_q);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept)
    else $error("command changed configuration");
endmodule

// File: test/rmc_bc_model.sv
/*
 rmc_bc_model: bus controller and encoder side of the handler.
 Assumes the handler samples message fields with msg_stb_o and
 that a status word takes dly cycles on the wire.
*/
`timescale 1ns/10ps
module rmc_bc_model
(
  input wire logic clk_i,
  input wire logic stat_tx_i,
  output logic msg_stb_o,
  output logic [10:0] msg_o,
  output logic status_sent_o
);
  int dly = 1;
  int cnt = 0;
  initial
  begin
    msg_stb_o = 1'b0;
    msg_o = 11'h000;
    status_sent_o = 1'b0;
  end
  // fields: ok, tr, mode[4:0], broadcast_flag, bus, illeg, extra
  task automatic send(input logic [10:0] f);
    @(posedge clk_i);
    msg_stb_o <= 1'b1;
    msg_o <= f;
    @(posedge clk_i);
    msg_stb_o <= 1'b0;
    // released fields never keep the old value
    msg_o <= ~f;
  endtask
  always @(posedge clk_i)
  begin
    status_sent_o <= 1'b0;
    if (stat_tx_i)
      cnt <= dly;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
        status_sent_o <= 1'b1;
    end
  end
endmodule

// File: test/rmc_handler_tb_top.sv
/*
 rmc_handler_tb_top: self-checking bench for the mode command handler.
 Assumes the 0x00/0x04/0x08/0x0C register layout and one-cycle answers.
*/
`timescale 1ns/10ps
module rmc_handler_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tfset = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic ack, mstb, ssent, stat, dwr, dacc, dbc, dpp, iwr, bwr;
  logic me, busy, bcr, tfinh, rreq, icmd, ibc, iill, ime;
  logic [10:0] m;
  logic [15:0] info, bitw;
  logic [1:0] shut;
  logic [1:0] pp = 2'b00;
  int mismatches = 0;
  int comparisons = 0;
  // row: ok,tr,mode,bc,bus,il,ex | wr,stat,acc,dbc,gap,wct,rt_to_rt_flag,ill,me
  logic [19:0] rows [12] = '{{11'h680, 9'h180}, {11'h68C, 9'h120},
    {11'h674, 9'h180}, {11'h280, 9'h000}, {11'h480, 9'h1C0},
    {11'h47C, 9'h160}, {11'h486, 9'h1C3}, {11'h47A, 9'h163},
    {11'h671, 9'h149}, {11'h685, 9'h151}, {11'h489, 9'h151},
    {11'h660, 9'h000}};

  always #25 clk_i = ~clk_i;

  rmc_bc_model rmc_bc_model_i
  (
    .clk_i(clk_i), .stat_tx_i(stat), .msg_stb_o(mstb), .msg_o(m),
    .status_sent_o(ssent)
  );
  rmc_handler rmc_handler_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .msg_stb_i(mstb), .msg_word_ok_i(m[10]), .msg_tr_i(m[9]),
    .msg_mode_i(m[8:4]), .msg_broadcast_flag_i(m[3]), .msg_bus_i(m[2]),
    .msg_illeg_i(m[1]), .msg_extra_i(m[0]), .tf_inh_set_i(tfset),
    .status_sent_i(ssent), .stat_tx_o(stat), .desc_wr_o(dwr),
    .desc_acc_o(dacc), .desc_broadcast_flag_o(dbc), .desc_pp_o(dpp),
    .info_wr_o(iwr), .info_o(info), .bitw_wr_o(bwr), .bitw_o(bitw),
    .msg_err_o(me), .busy_o(busy), .bcr_o(bcr), .tf_inh_o(tfinh),
    .tx_shut_o(shut), .reset_req_o(rreq), .irq_cmd_o(icmd),
    .irq_bc_o(ibc), .irq_ill_o(iill), .irq_me_o(ime)
  );

  task automatic chk(input logic ok, input string s);
    comparisons++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error %0t %s", $time, s);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(ack === 1'b1, "no bus answer");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    conclude();
  end

  initial
  begin
    logic [19:0] r;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 20; a += 4)
    begin
      wb(1'b0, a[7:0], 32'h0);
      chk(rd === 32'h0, "reset or unmapped read");
    end
    $display("register reset test done");
    wb(1'b1, rmc_pkg::OFS_IEN, 32'h0000000F);
    foreach (rows[k])
    begin
      r = rows[k];
      rmc_bc_model_i.send(r[19:9]);
      @(negedge clk_i);
      if (r[8])
        pp[r[13]] = ~pp[r[13]];
      chk(stat === r[7] && dwr === r[8] && iwr === r[8], "response");
      chk(icmd === r[8], "command irq");
      if (r[8])
      begin
        chk(dacc === r[6] && dbc === r[5] && dpp === pp[r[13]], "desc");
        chk(info === {10'h000, r[4:0], r[11]}, "info word");
        chk(ibc === r[5] && iill === r[1], "irq set");
        chk(ime === (r[4] | r[3]) && me === r[0], "error");
      end
    end
    $display("table test done");
    // option on: even an illegalized command must stay silent
    wb(1'b1, rmc_pkg::OFS_CFG, 32'h00000001);
    rmc_bc_model_i.send(11'h486);
    @(negedge clk_i);
    chk({stat, dwr, iwr, icmd, iill, ibc, ime} === 7'h00, "ignored");
    wb(1'b1, rmc_pkg::OFS_CFG, 32'h000000A4);
    wb(1'b1, rmc_pkg::OFS_IEN, 32'h00000000);
    rmc_bc_model_i.send(11'h47A);
    @(negedge clk_i);
    chk(dwr === 1'b1 && {icmd, ibc, iill} === 3'h0, "masked irq");
    $display("ignore and mask test done");
    wb(1'b1, rmc_pkg::OFS_IEN, 32'h0000000F);
    wb(1'b1, rmc_pkg::OFS_STAT, 32'h00000032);
    wb(1'b1, rmc_pkg::OFS_PEND, 32'h00000001);
    @(posedge clk_i);
    tfset <= 1'b1;
    @(posedge clk_i);
    tfset <= 1'b0;
    @(negedge clk_i);
    chk(tfinh === 1'b1 && shut === 2'h3 && busy === 1'b1, "setup");
    chk(rreq === 1'b0, "pending idle");
    rmc_bc_model_i.dly = 6;
    rmc_bc_model_i.send(11'h680);
    @(negedge clk_i);
    chk(bwr === 1'b1 && bitw === 16'h0000, "test word");
    chk(shut === 2'h0 && tfinh === 1'b0, "shutdown, inhibit");
    chk(me === 1'b0 && busy === 1'b1 && rreq === 1'b1, "pending");
    for (int i = 0; i < 30 && ssent !== 1'b1; i++)
      @(negedge clk_i);
    @(negedge clk_i);
    chk({me, busy, bcr} === 3'h0, "after status");
    wb(1'b0, rmc_pkg::OFS_CFG, 32'h0);
    chk(rd === 32'h000000A4, "config kept");
    wb(1'b1, rmc_pkg::OFS_PEND, 32'h00000001);
    wb(1'b0, rmc_pkg::OFS_PEND, 32'h0);
    chk(rd[0] === 1'b0 && rreq === 1'b0, "pending cleared");
    $display("terminal reset test done");
    @(posedge clk_i);
    tfset <= 1'b1;
    @(posedge clk_i);
    tfset <= 1'b0;
    @(negedge clk_i);
    chk(tfinh === 1'b1, "inhibit set");
    rmc_bc_model_i.send(11'h674);
    @(negedge clk_i);
    chk(tfinh === 1'b0 && stat === 1'b1, "override");
    // a message while the enable is low must leave no trace
    @(posedge clk_i);
    ce <= 1'b0;
    rmc_bc_model_i.send(11'h480);
    @(negedge clk_i);
    chk({dwr, iwr, stat, icmd} === 4'h0, "frozen by enable");
    @(posedge clk_i);
    ce <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({me, busy, bcr, tfinh, shut, rreq, stat, dwr} === 9'h000, "reset");
    wb(1'b0, rmc_pkg::OFS_CFG, 32'h0);
    chk(rd === 32'h0, "config after reset");
    $display("override, enable and reset test done");
    conclude();
  end
endmodule
